// ---- src/atc_down_counter.sv ----
// One 16-bit reloading down counter stage of the timer
`default_nettype none
module atc_down_counter
  import atc_pkg::*;
#(
  parameter int unsigned W = ATC_CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] reload,
  output logic [W-1:0] count,
  output logic wrap
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic wrap_r;
  wire at_one = (count_r <= W'(ATC_CNT_ONE));
  // A reload of zero behaves as one so the stage never stalls
  wire [W-1:0] load_val = (reload == W'(ATC_CNT_ZERO)) ?
                          W'(ATC_CNT_ONE) : reload;
  always_comb begin
    count_nxt = count_r;
    if (!run) begin
      count_nxt = load_val;
    end else if (tick) begin
      count_nxt = at_one ? load_val : count_r - W'(ATC_CNT_ONE);
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_r <= W'(ATC_CNT_RST);
      wrap_r <= 1'b0;
    end else if (ce) begin
      count_r <= count_nxt;
      wrap_r <= run && tick && at_one;
    end
  end
  assign count = count_r;
  assign wrap = wrap_r;
endmodule : atc_down_counter
`default_nettype wire

// ---- src/atc_pkg.sv ----
// Package of constants for the conversion trigger and counter clock block
`default_nettype none
package atc_pkg;
  localparam int unsigned ATC_CLK_HZ = 20_000_000;
  localparam int unsigned ATC_REF_HZ = 10_000_000;
  localparam int unsigned ATC_INT_HZ = 1_000_000;
  // Reference tick every REF_DIV clocks, internal 1 MHz every INT_DIV refs
  localparam int unsigned ATC_REF_DIV = ATC_CLK_HZ / ATC_REF_HZ;
  localparam int unsigned ATC_INT_DIV = ATC_REF_HZ / ATC_INT_HZ;
  localparam int unsigned ATC_CNT_W = 16;
  localparam logic [15:0] ATC_CNT_ONE = 16'h0001;
  localparam logic [15:0] ATC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] ATC_CNT_RST = 16'h0000;
  typedef enum logic [1:0] {
    ATC_TRG_NONE = 2'b00,
    ATC_TRG_PACER = 2'b01,
    ATC_TRG_EXT = 2'b10
  } atc_trg_mode_t;
  typedef enum logic {
    ATC_CLK_EXT = 1'b0,
    ATC_CLK_INT = 1'b1
  } atc_clk_src_t;
endpackage : atc_pkg
`default_nettype wire

// ---- src/atc_trigger_ctrl.sv ----
// Conversion trigger select, cascaded pacer timer and event counter
`default_nettype none
module atc_trigger_ctrl
  import atc_pkg::*;
#(
  parameter int unsigned W = ATC_CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic pacer_on,
  input wire logic [1:0] trg_mode,
  input wire logic evt_clk_sel,
  input wire logic evt_run,
  input wire logic [W-1:0] evt_reload,
  input wire logic [W-1:0] pacer_div_lo,
  input wire logic [W-1:0] pacer_div_hi,
  input wire logic event_counter_clock_in,
  input wire logic event_counter_gate_in,
  input wire logic ext_trigger_qualify,
  input wire logic ext_conversion_edge_in,
  output logic pacer_out,
  output logic event_counter_out,
  output logic conv_start,
  output logic [W-1:0] evt_count
);
  // Two-stage synchronisers; stage one feeds only stage two
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] prev_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r <= 4'h0;
    end else if (ce) begin
      sync1_r <= {event_counter_gate_in, event_counter_clock_in,
                  ext_trigger_qualify, ext_conversion_edge_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  // History resets low like the idle pins, so leaving reset makes no edge
  wire ext_conversion_edge_in_s = sync2_r[0];
  wire gate_s = sync2_r[1];
  wire ext_clk_rise = sync2_r[2] & ~prev_r[2];
  wire ext_conversion_edge_in_rise = ext_conversion_edge_in_s & ~prev_r[0];
  wire evt_gate_s = sync2_r[3];

  // Common 10 MHz reference tick and derived 1 MHz internal tick
  logic [7:0] ref_cnt_r;
  logic [7:0] int_cnt_r;
  wire ref_tick = (ref_cnt_r == 8'(ATC_REF_DIV - 1));
  wire int_tick = ref_tick && (int_cnt_r == 8'(ATC_INT_DIV - 1));
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_cnt_r <= 8'h00;
      int_cnt_r <= 8'h00;
    end else if (ce) begin
      ref_cnt_r <= ref_tick ? 8'h00 : ref_cnt_r + 8'h01;
      if (ref_tick) begin
        int_cnt_r <= (int_cnt_r == 8'(ATC_INT_DIV - 1)) ?
                     8'h00 : int_cnt_r + 8'h01;
      end
    end
  end

  // Event counter: source chosen by select, counts while gate is high
  wire evt_tick = (evt_clk_sel == ATC_CLK_INT) ? int_tick
                                                : ext_clk_rise;
  wire evt_wrap;
  atc_down_counter #(.W(W)) u_evt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(evt_run),
    .tick(evt_tick && evt_gate_s),
    .reload(evt_reload),
    .count(evt_count),
    .wrap(evt_wrap)
  );

  // Pacer: low stage feeds the high stage, a 32-bit divider in all
  wire lo_wrap;
  wire hi_wrap;
  atc_down_counter #(.W(W)) u_pacer_lo (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(pacer_on),
    .tick(ref_tick),
    .reload(pacer_div_lo),
    .count(),
    .wrap(lo_wrap)
  );
  atc_down_counter #(.W(W)) u_pacer_hi (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(pacer_on),
    .tick(lo_wrap),
    .reload(pacer_div_hi),
    .count(),
    .wrap(hi_wrap)
  );

  logic pacer_r;
  logic pacer_prev_r;
  logic evt_out_r;
  logic conv_r;
  // Pulse is one clock wide: at least one period apart since
  // the high stage only wraps after a reference tick
  wire pacer_nxt = pacer_on && hi_wrap;
  wire pacer_rise = pacer_r && !pacer_prev_r;
  wire ext_ok = ext_conversion_edge_in_rise && gate_s;
  // Codes 00 and the unused 11 start nothing
  wire conv_nxt = (trg_mode == ATC_TRG_PACER) ? pacer_rise :
                  (trg_mode == ATC_TRG_EXT) ? ext_ok : 1'b0;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pacer_r <= 1'b0;
      pacer_prev_r <= 1'b0;
      evt_out_r <= 1'b0;
      conv_r <= 1'b0;
    end else if (ce) begin
      pacer_r <= pacer_nxt;
      pacer_prev_r <= pacer_r;
      if (evt_wrap) begin
        evt_out_r <= ~evt_out_r;
      end
      conv_r <= conv_nxt;
    end
  end
  assign pacer_out = pacer_r;
  assign event_counter_out = evt_out_r;
  assign conv_start = conv_r;

  // Pacer and trigger path
  a_pacer_off_quiet: assert property (@(posedge clk)
    disable iff (!nrst)
    !$past(pacer_on) && !pacer_on |=> !pacer_out)
    else $error("pacer pulse while pacer off");
  a_pacer_needs_on: assert property (@(posedge clk)
    disable iff (!nrst)
    $past(ce) && pacer_out |-> $past(pacer_on))
    else $error("pacer pulse without enable");
  a_pacer_single: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && pacer_out |=> !pacer_out)
    else $error("pacer pulse too wide");
  a_pacer_conv_link: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && pacer_out && !$past(pacer_out) && trg_mode == ATC_TRG_PACER
    ##1 ce && trg_mode == ATC_TRG_PACER |-> conv_start)
    else $error("pacer edge did not start conversion");
  a_pacer_conv_src: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && trg_mode == ATC_TRG_PACER && !pacer_rise |=> !conv_start)
    else $error("conversion start without pacer edge");
  a_mode_none_idle: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && trg_mode == ATC_TRG_NONE |=> !conv_start)
    else $error("conversion start with triggers off");
  a_gate_blocks_ext: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && trg_mode == ATC_TRG_EXT && !gate_s |=> !conv_start)
    else $error("gated-off trigger started conversion");
  a_ext_edge_conv: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && trg_mode == ATC_TRG_EXT && ext_ok |=> conv_start)
    else $error("external edge lost");
  a_ext_conv_src: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && trg_mode == ATC_TRG_EXT && !ext_conversion_edge_in_rise |=> !conv_start)
    else $error("conversion start without external edge");
  a_conv_single: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_sync_two_stage: assert property (@(posedge clk)
    disable iff (!nrst)
    ce |=> sync2_r == $past(sync1_r))
    else $error("pin sampler skipped a stage");
  a_ext_rise_once: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && ext_conversion_edge_in_rise |=> !ext_conversion_edge_in_rise)
    else $error("external edge seen twice");

  // Timer and counter chain
  a_ref_period: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && ref_tick |=> !ref_tick)
    else $error("reference tick faster than 10 MHz");
  a_ref_drives_lo: assert property (@(posedge clk)
    disable iff (!nrst)
    $past(ce) && lo_wrap |-> $past(ref_tick))
    else $error("low stage wrapped without reference tick");
  a_lo_wrap_gap: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && lo_wrap |=> !lo_wrap)
    else $error("low stage wrapped twice in a row");
  a_cascade_src: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && $past(ce) && hi_wrap |-> $past(lo_wrap))
    else $error("high stage wrapped without low stage");
  a_int_clk_rate: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && int_tick |=> !int_tick [*8])
    else $error("internal counter clock too fast");
  a_evt_step_down: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && evt_run && evt_tick && evt_gate_s && evt_count > W'(ATC_CNT_ONE)
    |=> evt_count == $past(evt_count) - W'(ATC_CNT_ONE))
    else $error("event counter missed a tick");
  a_evt_no_tick: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && evt_run && !(evt_tick && evt_gate_s) |=> $stable(evt_count))
    else $error("event counter moved without a tick");
  a_evt_hold_reload: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && !evt_run |=> evt_count != W'(ATC_CNT_ZERO))
    else $error("stopped event counter holds zero");
  a_evt_out_toggle: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && evt_wrap |=> event_counter_out != $past(event_counter_out))
    else $error("event counter output missed a wrap");
endmodule : atc_trigger_ctrl
`default_nettype wire

// ---- tb/adc_trigger_and_counter_clock_tb.sv ----
// Self-checking bench for the conversion trigger block
`default_nettype none
module adc_trigger_and_counter_clock_tb;
  import atc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, pon = 1'b0, sel = 1'b0, run = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] rld = 16'h0005, dlo = 16'h0002, dhi = 16'h0003, cnt;
  logic trg, qual, eclk, egate, pac, eout, conv;
  int fail_count = 0, checked = 0, n_conv = 0, n_pac = 0;
  realtime t_conv = 0, t_rise;
  atc_field_model fw (.clk(clk), .trg(trg), .qual(qual), .eclk(eclk),
    .egate(egate));
  atc_trigger_ctrl uut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .pacer_on(pon), .trg_mode(mode), .evt_clk_sel(sel), .evt_run(run),
    .evt_reload(rld), .pacer_div_lo(dlo), .pacer_div_hi(dhi),
    .event_counter_clock_in(eclk), .event_counter_gate_in(egate),
    .ext_trigger_qualify(qual), .ext_conversion_edge_in(trg),
    .pacer_out(pac), .event_counter_out(eout), .conv_start(conv),
    .evt_count(cnt));
  initial forever #25 clk = ~clk;
  // Sampled mid-cycle so the counts never race the edge that clears them
  always @(negedge clk) begin
    if (conv === 1'b1) n_conv++;
    if (conv === 1'b1) t_conv = $realtime;
    if (pac === 1'b1) n_pac++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $realtime, got, exp);
    end
  endtask : chk
  task automatic clr(input int n);
    repeat (n) @(posedge clk);
    {n_conv, n_pac} = 0;
  endtask : clr
  task automatic t_pacer;
    mode <= ATC_TRG_PACER;
    clr(48);
    repeat (48) @(posedge clk);
    chk(16'(n_pac), 16'h0000);
    pon <= 1'b1;
    clr(48);
    // Window of ten pacer periods, 2*2*3 clocks each
    repeat (120) @(posedge clk);
    chk(16'(n_pac), 16'h000A);
    chk(16'(n_conv), 16'h000A);
    pon <= 1'b0;
  endtask : t_pacer
  task automatic t_ext;
    mode <= ATC_TRG_EXT;
    fw.hold(1'b1, 1'b0);
    clr(8);
    repeat (3) fw.pulse(1'b0, t_rise);
    chk(16'(n_conv), 16'h0003);
    // Three sampler cycles to the start pulse, seen at the falling edge
    chk(16'(int'(t_conv - t_rise)), 16'h00AF);
    fw.hold(1'b0, 1'b0);
    clr(4);
    repeat (2) fw.pulse(1'b0, t_rise);
    chk(16'(n_conv), 16'h0000);
    mode <= ATC_TRG_NONE;
    fw.hold(1'b1, 1'b0);
    clr(4);
    fw.pulse(1'b0, t_rise);
    chk(16'(n_conv), 16'h0000);
  endtask : t_ext
  task automatic t_evt;
    fw.hold(1'b0, 1'b1);
    chk(cnt, 16'h0005);
    run <= 1'b1;
    repeat (3) fw.pulse(1'b1, t_rise);
    chk(cnt, 16'h0002);
    // Two more edges reach the end of the count and reload it
    repeat (2) fw.pulse(1'b1, t_rise);
    chk(16'(eout), 16'h0001);
    chk(cnt, 16'h0005);
    fw.hold(1'b0, 1'b0);
    fw.pulse(1'b1, t_rise);
    chk(cnt, 16'h0005);
    fw.hold(1'b0, 1'b1);
    sel <= 1'b1;
    run <= 1'b0;
    rld <= 16'h0100;
    repeat (4) @(posedge clk);
    run <= 1'b1;
    // Twenty ticks of the 1 MHz internal tick; phase may cost one
    repeat (400) @(posedge clk);
    chk(16'(cnt inside {[16'h00EB : 16'h00ED]}), 16'h0001);
  endtask : t_evt
  task automatic end_sim;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    #200us;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_pacer();
    t_ext();
    t_evt();
    end_sim();
  end
endmodule : adc_trigger_and_counter_clock_tb
`default_nettype wire

// ---- tb/atc_field_model.sv ----
// Field wiring model: trigger, gate and counter clock pins
`default_nettype none
module atc_field_model (
  input wire logic clk,
  output logic trg,
  output logic qual,
  output logic eclk,
  output logic egate
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {trg, qual, eclk, egate} = 4'h0;
  // Gates are levels held well past the two-stage sampler
  task automatic hold(input logic q, input logic g);
    @(posedge clk);
    qual <= q;
    egate <= g;
    repeat (4) @(posedge clk);
  endtask : hold
  // Four cycles per level keeps every edge visible after sampling
  task automatic pulse(input bit ck, output realtime t);
    @(posedge clk);
    t = $realtime;
    if (ck) eclk <= 1'b1;
    else trg <= 1'b1;
    repeat (4) @(posedge clk);
    {trg, eclk} <= 2'h0;
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : atc_field_model
`default_nettype wire
